//--- hdl/tmr_cfg.svh
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
// Overview of operation
// R01: Writing one resets the shared prescaler
// R02: Reset bit self-clears; writing zero ignored
// R03: Prescaler reset bit always reads zero
// R04: Prescaler restart reaches both attached timers
// R05: Counter, compares, capture 16 bits; controls 8
// R06: Flags visible and each gated by mask
// R07: No clock source: counter holds, inactive
// R08: Tick from prescaler or external pin edges
// R09: Compares checked against counter every cycle; code signals a match only on tick cycles
// R10: Compare match sets its channel flag
// R11: Capture edge copies counter, optional filter
// R12: TOP fixed 0x00FF/0x01FF/0x03FF, compare A, capture
// R13: Compare A as PWM TOP drives no output
// R14: BOTTOM is 0x0000, MAX is 0xFFFF
// R15: One shared 8-bit high byte holding register
// R16: Low byte write loads full word
// R17: Low byte read latches high byte
// R18: Compare high byte reads bypass holding register
// R19: Software writes high first, reads low first
// R20: Force bits in A, mode bit3 in B
// R21: CPU counter write beats clear or count
// R22: Select zero stops; counter stays accessible
// R23: Separate byte addresses; high write only holds
`define TMR_A_FLAG 6'h00
`define TMR_A_MASK 6'h01
`define TMR_A_SFIO 6'h02
`define TMR_A_CTLA 6'h03
`define TMR_A_CTLB 6'h04
`define TMR_A_CNTL 6'h05
`define TMR_A_CNTH 6'h06
`define TMR_A_CMPAL 6'h07
`define TMR_A_CMPAH 6'h08
`define TMR_A_CMPBL 6'h09
`define TMR_A_CMPBH 6'h0a
`define TMR_A_CAPL 6'h0b
`define TMR_A_CAPH 6'h0c
`define TMR_F_TOV 2
`define TMR_F_MB 3
`define TMR_F_MA 4
`define TMR_F_CAP 5
`define TMR_FLAG_BITS 8'h3c
`define TMR_B_PSR 0
`define TMR_A_FOCA 3
`define TMR_A_FOCB 2
`define TMR_A_FOC_BITS 8'h0c
`define TMR_B_NC 7
`define TMR_B_EDGE 6
`define TMR_B_WGM3 4
`define TMR_B_WGM2 3
`define TMR_B_CS 2:0
`define TMR_A_WGM 1:0
`define TMR_TOP8 16'h00ff
`define TMR_TOP9 16'h01ff
`define TMR_TOP10 16'h03ff
`define TMR_BOTTOM 16'h0000
`define TMR_MAX 16'hffff
`define TMR_TAP8 3
`define TMR_TAP64 6
`define TMR_TAP256 8
`define TMR_TAP1024 10
`endif

//--- hdl/tmr_pkg.sv
package tmr_pkg;
   typedef enum logic [2:0] {
      CS_STOP = 3'b000, CS_DIV1 = 3'b001, CS_DIV8 = 3'b010,
      CS_DIV64 = 3'b011, CS_DIV256 = 3'b100, CS_DIV1024 = 3'b101,
      CS_EXT_FALL = 3'b110, CS_EXT_RISE = 3'b111
   } tmr_clksel_t;
   typedef enum logic [1:0] {
      SL_NORMAL = 2'b00, SL_CTC = 2'b01, SL_FAST = 2'b10, SL_DUAL = 2'b11
   } tmr_slope_t;
   typedef enum logic [2:0] {
      TS_MAX = 3'b000, TS_8 = 3'b001, TS_9 = 3'b010,
      TS_10 = 3'b011, TS_CMPA = 3'b100, TS_CAP = 3'b101
   } tmr_topsel_t;
endpackage : tmr_pkg

//--- hdl/tmr_presc.sv
`timescale 1ns/1ns
module tmr_presc #(
   parameter int W = 10
) (
   input wire logic clk, // System clock
   input wire logic rstn, // Sync reset, active low
   input wire logic ce, // Clock enable
   input wire logic clr, // Restart the divider
   output logic [W-1:0] cnt // Free running count
);
   // Free running, unaffected by clock select
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt <= '0;
      end else if (ce) begin
         if (clr) begin
            cnt <= '0;
         end else begin
            cnt <= cnt + 1'b1;
         end
      end
   end
endmodule : tmr_presc

//--- hdl/tmr_edge.sv
`timescale 1ns/1ns
module tmr_edge (
   input wire logic clk, // System clock
   input wire logic rstn, // Sync reset, active low
   input wire logic ce, // Clock enable
   input wire logic pin, // Asynchronous pin
   output logic lvl, // Synchronised level
   output logic rise, // Rising edge pulse
   output logic fall // Falling edge pulse
);
   logic s1_q, s2_q, s3_q;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else if (ce) begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   assign lvl = s2_q;
   assign rise = s2_q & ~s3_q;
   assign fall = ~s2_q & s3_q;
endmodule : tmr_edge

//--- hdl/tmr_core.sv
`timescale 1ns/1ns
`include "tmr_cfg.svh"
module tmr_core import tmr_pkg::*; #(
   parameter int PW = 10,
   parameter int NCLEN = 4
) (
   input wire logic CLK, // System clock, 125 MHz
   input wire logic RSTN, // Sync reset, active low
   input wire logic CE, // Freezes all state when low
   input wire logic [5:0] IO_ADDR, // I/O register address
   input wire logic IO_WR, // Write strobe
   input wire logic IO_RD, // Read strobe
   input wire logic [7:0] IO_WDATA, // Write data
   input wire logic EXT_COUNT_PIN, // External count pin
   input wire logic CAPTURE_PIN, // Capture pin
   input wire logic ACMP_OUT, // Analog comparator output
   input wire logic CAPT_FROM_ACMP, // Capture source select
   output logic [7:0] IO_RDATA, // Read data, next cycle
   output logic IRQ, // Any unmasked flag
   output logic WAVE_OUT_A, // Waveform channel A
   output logic WAVE_OUT_B, // Waveform channel B
   output logic PRESC_CLR // Prescaler restart to other timer
);
   logic [7:0] temp_q, ctla_q, ctlb_q, flag_q, mask_q, rdata_q;
   logic [15:0] cnt_q, ocra_q, ocrb_q, ocra_buf_q, ocrb_buf_q, icr_q;
   logic down_q, psr_q, wa_q, wb_q, irq_q;
   logic [NCLEN-1:0] nc_q;
   logic filt_q, cprev_q;
   logic [PW-1:0] pcnt;
   logic wr, rd, tick, t_rise, t_fall, c_lvl_raw, c_lvl, cap_ev;
   logic at_top, at_bot, ev_tov, ev_ma, ev_mb, ev_cap, pwm;
   logic [3:0] wgm;
   logic [15:0] top_v;
   logic [7:0] flag_clr, flag_set, rd_v;
   tmr_clksel_t cs;
   tmr_slope_t slope;
   tmr_topsel_t topsel;

   function automatic tmr_slope_t slope_of(input logic [3:0] m);
      unique case (m)
         4'h0, 4'hd: return SL_NORMAL;
         4'h4, 4'hc: return SL_CTC;
         4'h5, 4'h6, 4'h7, 4'he, 4'hf: return SL_FAST;
         4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: return SL_DUAL;
      endcase
   endfunction : slope_of
   function automatic tmr_topsel_t top_of(input logic [3:0] m);
      unique case (m)
         4'h0, 4'hd: return TS_MAX;
         4'h1, 4'h5: return TS_8;
         4'h2, 4'h6: return TS_9;
         4'h3, 4'h7: return TS_10;
         4'h4, 4'h9, 4'hb, 4'hf: return TS_CMPA;
         4'h8, 4'ha, 4'hc, 4'he: return TS_CAP;
      endcase
   endfunction : top_of
   // Tap fires once per divide period
   function automatic logic tap_hit(input logic [PW-1:0] c, input int k);
      logic [PW-1:0] m;
      m = PW'((1 << k) - 1);
      return (c & m) == m;
   endfunction : tap_hit
   function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
      return a == r;
   endfunction : hit
   assign wr = CE & IO_WR;
   assign rd = CE & IO_RD;
   assign wgm = {ctlb_q[`TMR_B_WGM3], ctlb_q[`TMR_B_WGM2], ctla_q[`TMR_A_WGM]}; // R20
   assign cs = tmr_clksel_t'(ctlb_q[`TMR_B_CS]);
   assign slope = slope_of(wgm);
   assign topsel = top_of(wgm);
   assign pwm = (slope == SL_FAST) || (slope == SL_DUAL);
   tmr_presc #(.W(PW)) u_presc (
      .clk(CLK),
      .rstn(RSTN),
      .ce(CE),
      .clr(psr_q), // R01 R04
      .cnt(pcnt)
   );
   tmr_edge u_tpin (
      .clk(CLK),
      .rstn(RSTN),
      .ce(CE),
      .pin(EXT_COUNT_PIN),
      .lvl(),
      .rise(t_rise),
      .fall(t_fall)
   );
   tmr_edge u_cpin (
      .clk(CLK),
      .rstn(RSTN),
      .ce(CE),
      .pin(CAPT_FROM_ACMP ? ACMP_OUT : CAPTURE_PIN),
      .lvl(c_lvl_raw),
      .rise(),
      .fall()
   );
   // Timer tick source
   always_comb begin
      unique case (cs) // R08
         CS_STOP: tick = 1'b0; // R07 R22
         CS_DIV1: tick = 1'b1;
         CS_DIV8: tick = tap_hit(pcnt, `TMR_TAP8);
         CS_DIV64: tick = tap_hit(pcnt, `TMR_TAP64);
         CS_DIV256: tick = tap_hit(pcnt, `TMR_TAP256);
         CS_DIV1024: tick = tap_hit(pcnt, `TMR_TAP1024);
         CS_EXT_FALL: tick = t_fall;
         CS_EXT_RISE: tick = t_rise;
      endcase
   end
   always_comb begin
      case (topsel) // R12
         TS_8: top_v = `TMR_TOP8;
         TS_9: top_v = `TMR_TOP9;
         TS_10: top_v = `TMR_TOP10;
         TS_CMPA: top_v = ocra_q; // R13
         TS_CAP: top_v = icr_q;
         default: top_v = `TMR_MAX;
      endcase
   end

   assign at_top = cnt_q == top_v;
   assign at_bot = cnt_q == `TMR_BOTTOM; // R14
   always_comb begin
      unique case (slope)
         SL_NORMAL, SL_CTC: ev_tov = tick & (cnt_q == `TMR_MAX); // R14
         SL_FAST: ev_tov = tick & at_top;
         SL_DUAL: ev_tov = tick & at_bot & down_q;
      endcase
   end

   assign ev_ma = tick & (cnt_q == ocra_q); // R09 R10
   assign ev_mb = tick & (cnt_q == ocrb_q); // R09 R10
   // Counter; a CPU write overrides any tick
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         cnt_q <= `TMR_BOTTOM;
         down_q <= 1'b0;
      end else if (CE) begin
         if (wr && hit(IO_ADDR, `TMR_A_CNTL)) begin
            cnt_q <= {temp_q, IO_WDATA}; // R16 R21 R22
         end else if (tick) begin
            if (slope != SL_DUAL) begin
               down_q <= 1'b0;
               cnt_q <= at_top ? `TMR_BOTTOM : cnt_q + 16'h0001;
            end else if (!down_q) begin
               down_q <= at_top;
               cnt_q <= at_top ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
            end else begin
               down_q <= !at_bot;
               cnt_q <= at_bot ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
            end
         end
      end
   end

   // Shared high byte holding register
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         temp_q <= 8'h00;
      end else if (CE) begin
         if (wr && (hit(IO_ADDR, `TMR_A_CNTH) || hit(IO_ADDR, `TMR_A_CMPAH) ||
             hit(IO_ADDR, `TMR_A_CMPBH) || hit(IO_ADDR, `TMR_A_CAPH))) begin
            temp_q <= IO_WDATA; // R15 R23
         end else if (rd && hit(IO_ADDR, `TMR_A_CNTL)) begin
            temp_q <= cnt_q[15:8]; // R17
         end else if (rd && hit(IO_ADDR, `TMR_A_CAPL)) begin
            temp_q <= icr_q[15:8]; // R17
         end
      end
   end

   // Compare buffers: immediate outside PWM, else at period edge
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         ocra_buf_q <= `TMR_BOTTOM;
         ocrb_buf_q <= `TMR_BOTTOM;
         ocra_q <= `TMR_BOTTOM;
         ocrb_q <= `TMR_BOTTOM;
      end else if (CE) begin
         if (wr && hit(IO_ADDR, `TMR_A_CMPAL)) begin
            ocra_buf_q <= {temp_q, IO_WDATA}; // R16
         end
         if (wr && hit(IO_ADDR, `TMR_A_CMPBL)) begin
            ocrb_buf_q <= {temp_q, IO_WDATA}; // R16
         end
         if (!pwm || (tick && ((slope == SL_FAST) ? at_top : at_bot))) begin
            ocra_q <= ocra_buf_q; // R13
            ocrb_q <= ocrb_buf_q;
         end
      end
   end

   // Capture input, optional four sample filter
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         nc_q <= '0;
         filt_q <= 1'b0;
         cprev_q <= 1'b0;
      end else if (CE) begin
         nc_q <= {nc_q[NCLEN-2:0], c_lvl_raw};
         if (&nc_q) begin
            filt_q <= 1'b1;
         end else if (~|nc_q) begin
            filt_q <= 1'b0;
         end
         cprev_q <= c_lvl;
      end
   end
   assign c_lvl = ctlb_q[`TMR_B_NC] ? filt_q : c_lvl_raw; // R11
   assign cap_ev = ctlb_q[`TMR_B_EDGE] ? (c_lvl & ~cprev_q) : (~c_lvl & cprev_q);
   // Capture is off while the capture register serves as TOP
   assign ev_cap = (topsel == TS_CAP) ? (tick & at_top) : cap_ev;
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         icr_q <= `TMR_BOTTOM;
      end else if (CE) begin
         if (wr && hit(IO_ADDR, `TMR_A_CAPL)) begin
            icr_q <= {temp_q, IO_WDATA}; // R16
         end else if (cap_ev && topsel != TS_CAP) begin
            icr_q <= cnt_q; // R11
         end
      end
   end

   // Flags: set beats a same-cycle write-one clear
   assign flag_clr = (wr && hit(IO_ADDR, `TMR_A_FLAG)) ? IO_WDATA : 8'h00;
   always_comb begin
      flag_set = 8'h00;
      flag_set[`TMR_F_TOV] = ev_tov;
      flag_set[`TMR_F_MA] = ev_ma; // R10
      flag_set[`TMR_F_MB] = ev_mb; // R10
      flag_set[`TMR_F_CAP] = ev_cap;
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         flag_q <= 8'h00;
         mask_q <= 8'h00;
         irq_q <= 1'b0;
      end else if (CE) begin
         flag_q <= ((flag_q & ~flag_clr) | flag_set) & `TMR_FLAG_BITS; // R06
         if (wr && hit(IO_ADDR, `TMR_A_MASK)) begin
            mask_q <= IO_WDATA & `TMR_FLAG_BITS;
         end
         irq_q <= |(flag_q & mask_q); // R06
      end
   end

   // Control registers; force bits are strobes only
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         ctla_q <= 8'h00;
         ctlb_q <= 8'h00;
         psr_q <= 1'b0;
      end else if (CE) begin
         if (wr && hit(IO_ADDR, `TMR_A_CTLA)) begin
            ctla_q <= IO_WDATA & ~`TMR_A_FOC_BITS; // R05 R20
         end
         if (wr && hit(IO_ADDR, `TMR_A_CTLB)) begin
            ctlb_q <= IO_WDATA; // R05
         end
         psr_q <= wr && hit(IO_ADDR, `TMR_A_SFIO) && IO_WDATA[`TMR_B_PSR]; // R01 R02
      end
   end

   // Waveform outputs
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         wa_q <= 1'b0;
         wb_q <= 1'b0;
      end else if (CE) begin
         if (!pwm) begin
            if (ev_ma || (wr && hit(IO_ADDR, `TMR_A_CTLA) && IO_WDATA[`TMR_A_FOCA])) begin
               wa_q <= !wa_q; // R09 R20
            end
            if (ev_mb || (wr && hit(IO_ADDR, `TMR_A_CTLA) && IO_WDATA[`TMR_A_FOCB])) begin
               wb_q <= !wb_q; // R09 R20
            end
         end else begin
            if (topsel == TS_CMPA) begin
               wa_q <= 1'b0; // R13
            end else if (ev_ma) begin
               wa_q <= (slope == SL_DUAL) && down_q;
            end else if (slope == SL_FAST && tick && at_top) begin
               wa_q <= 1'b1;
            end
            if (ev_mb) begin
               wb_q <= (slope == SL_DUAL) && down_q;
            end else if (slope == SL_FAST && tick && at_top) begin
               wb_q <= 1'b1;
            end
         end
      end
   end

   // Read path
   always_comb begin
      case (IO_ADDR)
         `TMR_A_FLAG: rd_v = flag_q;
         `TMR_A_MASK: rd_v = mask_q;
         `TMR_A_SFIO: rd_v = 8'h00; // R03
         `TMR_A_CTLA: rd_v = ctla_q;
         `TMR_A_CTLB: rd_v = ctlb_q;
         `TMR_A_CNTL: rd_v = cnt_q[7:0];
         `TMR_A_CNTH: rd_v = temp_q; // R15
         `TMR_A_CMPAL: rd_v = ocra_buf_q[7:0];
         `TMR_A_CMPAH: rd_v = ocra_buf_q[15:8]; // R18
         `TMR_A_CMPBL: rd_v = ocrb_buf_q[7:0];
         `TMR_A_CMPBH: rd_v = ocrb_buf_q[15:8]; // R18
         `TMR_A_CAPL: rd_v = icr_q[7:0];
         `TMR_A_CAPH: rd_v = temp_q;
         default: rd_v = 8'h00;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         rdata_q <= 8'h00;
      end else if (CE) begin
         rdata_q <= rd ? rd_v : 8'h00;
      end
   end

   assign IO_RDATA = rdata_q;
   assign IRQ = irq_q;
   assign WAVE_OUT_A = wa_q;
   assign WAVE_OUT_B = wb_q;
   assign PRESC_CLR = psr_q;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   psr_set_a: assert property (wr && hit(IO_ADDR, `TMR_A_SFIO) && IO_WDATA[`TMR_B_PSR]
      |=> PRESC_CLR) // R01
      else $error("prescaler reset not raised");
   psr_clear_a: assert property (psr_q && CE && !(wr && hit(IO_ADDR, `TMR_A_SFIO))
      |=> !psr_q) // R02
      else $error("prescaler reset bit stuck");
   psr_read_a: assert property (rd && hit(IO_ADDR, `TMR_A_SFIO) |=> IO_RDATA == 8'h00) // R03
      else $error("prescaler reset bit read nonzero");
   presc_restart_a: assert property (psr_q && CE |=> pcnt == '0) // R04
      else $error("prescaler not restarted");
   cnt_write_a: assert property (wr && hit(IO_ADDR, `TMR_A_CNTL)
      |=> cnt_q == {$past(temp_q), $past(IO_WDATA)}) // R16
      else $error("counter low write did not load word");
   cnt_stop_a: assert property (CE && cs == CS_STOP && !(wr && hit(IO_ADDR, `TMR_A_CNTL))
      |=> $stable(cnt_q)) // R07
      else $error("stopped counter moved");
   temp_copy_a: assert property (rd && !wr && hit(IO_ADDR, `TMR_A_CNTL)
      |=> temp_q == 8'($past(cnt_q) >> 8)) // R17
      else $error("high byte not latched on low read");
   hi_write_a: assert property (wr && hit(IO_ADDR, `TMR_A_CMPAH)
      |=> $stable(ocra_buf_q) && temp_q == $past(IO_WDATA)) // R23
      else $error("high byte write touched target");
   match_flag_a: assert property (CE && ev_ma |=> flag_q[`TMR_F_MA]) // R10
      else $error("match flag not set");
   capture_a: assert property (CE && cap_ev && topsel != TS_CAP && !wr
      |=> icr_q == $past(cnt_q) && flag_q[`TMR_F_CAP]) // R11
      else $error("capture missed");
   irq_gate_a: assert property (CE |=> IRQ == |($past(flag_q) & $past(mask_q))) // R06
      else $error("interrupt gating wrong");
   pwm_top_a: assert property (CE && pwm && topsel == TS_CMPA |=> !WAVE_OUT_A) // R13
      else $error("compare A drove output as TOP");
   cap_c: cover property (CE && ev_cap);
   dual_tov_c: cover property (CE && ev_tov && slope == SL_DUAL);
   both_match_c: cover property (CE && ev_ma && ev_mb);
   cap_read_c: cover property (rd && hit(IO_ADDR, `TMR_A_CAPH));
endmodule : tmr_core

//--- sim/tmr_cpu_model.sv
`timescale 1ns/1ns
module tmr_cpu_model (
   input wire logic clk, // System clock
   output logic [5:0] io_addr, // Register address
   output logic io_wr, // Write strobe
   output logic io_rd, // Read strobe
   output logic [7:0] io_wdata, // Write data
   input wire logic [7:0] io_rdata // Registered read data
);
   initial begin
      io_addr = 6'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
   end

   // Bus lines show garbage once a strobe drops, so stale values never pass
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge clk);
      io_wr <= 1'b0;
      io_wdata <= ~d;
      io_addr <= ~a;
   endtask : wr

   // Data is registered, so it is picked up half a cycle after the taking edge
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge clk);
      io_rd <= 1'b0;
      io_addr <= ~a;
      @(negedge clk);
      d = io_rdata;
   endtask : rd

   task automatic wr16(input logic [5:0] lo, input logic [15:0] v);
      wr(lo + 6'h01, v[15:8]);
      wr(lo, v[7:0]);
   endtask : wr16

   task automatic rd16(input logic [5:0] lo, output logic [15:0] v);
      rd(lo, v[7:0]);
      rd(lo + 6'h01, v[15:8]);
   endtask : rd16
endmodule : tmr_cpu_model

//--- sim/timer16_register_access_core_tb_top.sv
`timescale 1ns/1ns
`include "tmr_cfg.svh"
`define CHK(nm, exp, got) begin \
   samples_checked++; \
   if ((got) !== (exp)) begin \
      errors++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
   end \
end
module timer16_register_access_core_tb_top import tmr_pkg::*;;
   typedef struct packed {
      logic [5:0] a;
      logic [7:0] w;
      logic [7:0] e;
   } tmr_row_t;
   localparam int NROWS = 11;
   logic clk;
   logic rstn;
   logic ce;
   logic ext_pin;
   logic cap_pin;
   logic acmp;
   logic cap_sel;
   logic [5:0] io_addr;
   logic io_wr;
   logic io_rd;
   logic [7:0] io_wdata;
   logic [7:0] io_rdata;
   logic irq;
   logic wave_a;
   logic wave_b;
   logic presc_clr;
   int errors = 0;
   int samples_checked = 0;
   logic [7:0] b;
   logic [15:0] w;
   tmr_row_t rows [NROWS] = '{
      '{`TMR_A_MASK, 8'hff, 8'h3c},
      '{`TMR_A_MASK, 8'h00, 8'h00},
      '{`TMR_A_FLAG, 8'hff, 8'h00},
      '{`TMR_A_CTLA, 8'hff, 8'hf3},
      '{`TMR_A_CTLA, 8'h00, 8'h00},
      '{`TMR_A_CTLB, 8'hd8, 8'hd8},
      '{`TMR_A_CTLB, 8'h00, 8'h00},
      '{`TMR_A_SFIO, 8'h01, 8'h00},
      '{`TMR_A_SFIO, 8'h00, 8'h00},
      '{6'h3f, 8'hff, 8'h00},
      '{`TMR_A_CMPBH, 8'h55, 8'h00}
   };

   tmr_core DUT (.CLK(clk), .RSTN(rstn), .CE(ce), .IO_ADDR(io_addr), .IO_WR(io_wr),
      .IO_RD(io_rd), .IO_WDATA(io_wdata), .EXT_COUNT_PIN(ext_pin),
      .CAPTURE_PIN(cap_pin), .ACMP_OUT(acmp), .CAPT_FROM_ACMP(cap_sel),
      .IO_RDATA(io_rdata), .IRQ(irq), .WAVE_OUT_A(wave_a), .WAVE_OUT_B(wave_b),
      .PRESC_CLR(presc_clr));

   tmr_cpu_model cpu (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   // Slow pulses: each half period spans several clocks for the synchroniser
   task automatic ext_edges(input int n);
      repeat (n) begin
         @(posedge clk);
         ext_pin <= 1'b1;
         repeat (3) @(posedge clk);
         ext_pin <= 1'b0;
         repeat (2) @(posedge clk);
      end
      repeat (6) @(posedge clk);
   endtask : ext_edges

   initial begin
      repeat (6000) @(posedge clk);
      errors++;
      tally_and_finish();
   end

   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      ext_pin = 1'b0;
      cap_pin = 1'b0;
      acmp = 1'b0;
      cap_sel = 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i <= 12; i++) begin
         cpu.rd(6'(i), b);
         `CHK("reset read", 8'h00, b)
      end
      `CHK("reset irq", 1'b0, irq)
      for (int i = 0; i < NROWS; i++) begin
         cpu.wr(rows[i].a, rows[i].w);
         cpu.rd(rows[i].a, b);
         `CHK("row read", rows[i].e, b)
      end
      // Word transfers through the holding byte
      cpu.wr16(`TMR_A_CNTL, 16'h01ff);
      cpu.rd16(`TMR_A_CNTL, w);
      `CHK("count word", 16'h01ff, w)
      cpu.wr(`TMR_A_CNTH, 8'h77);
      cpu.rd16(`TMR_A_CNTL, w);
      `CHK("count after lone high", 16'h01ff, w)
      cpu.wr(`TMR_A_CMPAH, 8'hab);
      cpu.wr(`TMR_A_CMPAL, 8'h11);
      cpu.wr(`TMR_A_CMPBL, 8'h22);
      cpu.rd(`TMR_A_CMPBH, b);
      `CHK("shared hold", 8'hab, b)
      cpu.rd(`TMR_A_CNTL, b);
      cpu.rd(`TMR_A_CMPAH, b);
      `CHK("compare high direct", 8'hab, b)
      cpu.rd(`TMR_A_CMPAL, b);
      `CHK("compare low", 8'h11, b)
      // Prescaler restart strobe
      cpu.wr(`TMR_A_SFIO, 8'h01);
      @(negedge clk);
      `CHK("restart pulse", 1'b1, presc_clr)
      @(negedge clk);
      `CHK("restart ends", 1'b0, presc_clr)
      cpu.wr(`TMR_A_SFIO, 8'h00);
      @(negedge clk);
      `CHK("zero write", 1'b0, presc_clr)
      // Counting across MAX on external edges
      cpu.wr16(`TMR_A_CMPAL, 16'hffff);
      cpu.wr16(`TMR_A_CMPBL, 16'h1234);
      cpu.wr16(`TMR_A_CNTL, 16'hfffe);
      ext_edges(2);
      cpu.rd16(`TMR_A_CNTL, w);
      `CHK("stopped count", 16'hfffe, w)
      cpu.wr(`TMR_A_CTLB, 8'h07);
      ext_edges(3);
      cpu.wr(`TMR_A_CTLB, 8'h00);
      cpu.rd16(`TMR_A_CNTL, w);
      `CHK("rising count", 16'h0001, w)
      `CHK("match toggles a", 1'b0, wave_a)
      `CHK("forced b", 1'b1, wave_b)
      cpu.rd(`TMR_A_FLAG, b);
      `CHK("flags", 8'h14, b)
      `CHK("masked irq", 1'b0, irq)
      cpu.wr(`TMR_A_MASK, 8'h04);
      repeat (2) @(negedge clk);
      `CHK("unmasked irq", 1'b1, irq)
      cpu.wr(`TMR_A_FLAG, 8'h04);
      repeat (2) @(negedge clk);
      `CHK("cleared irq", 1'b0, irq)
      cpu.wr(`TMR_A_CTLB, 8'h06);
      ext_edges(2);
      cpu.wr(`TMR_A_CTLB, 8'h00);
      cpu.rd16(`TMR_A_CNTL, w);
      `CHK("falling count", 16'h0003, w)
      // Capture from the pin, then from the comparator
      cpu.wr16(`TMR_A_CNTL, 16'h0345);
      cpu.wr(`TMR_A_CTLB, 8'h40);
      @(posedge clk);
      cap_pin <= 1'b1;
      repeat (8) @(posedge clk);
      cpu.rd16(`TMR_A_CAPL, w);
      `CHK("pin capture", 16'h0345, w)
      cpu.rd(`TMR_A_FLAG, b);
      `CHK("capture flag", 8'h30, b)
      cpu.wr16(`TMR_A_CNTL, 16'h0abc);
      @(posedge clk);
      cap_sel <= 1'b1;
      repeat (4) @(posedge clk);
      acmp <= 1'b1;
      repeat (8) @(posedge clk);
      cpu.rd16(`TMR_A_CAPL, w);
      `CHK("comparator capture", 16'h0abc, w)
      // Fast PWM, compare A as TOP, counted on external edges
      cpu.wr16(`TMR_A_CMPAL, 16'h0004);
      cpu.wr16(`TMR_A_CMPBL, 16'h0002);
      cpu.wr16(`TMR_A_CNTL, 16'h0000);
      cpu.wr(`TMR_A_FLAG, 8'hff);
      cpu.wr(`TMR_A_CTLA, 8'h03);
      cpu.wr(`TMR_A_CTLB, 8'h1f);
      ext_edges(8);
      cpu.wr(`TMR_A_CTLB, 8'h18);
      cpu.rd16(`TMR_A_CNTL, w);
      `CHK("top wrap count", 16'h0003, w)
      `CHK("top wave a", 1'b0, wave_a)
      `CHK("pwm wave b", 1'b0, wave_b)
      cpu.rd(`TMR_A_FLAG, b);
      `CHK("pwm flags", 8'h1c, b)
      `CHK("pwm irq", 1'b1, irq)
      // CPU write lands although a tick falls in the same cycle
      cpu.wr(`TMR_A_CTLA, 8'h00);
      cpu.wr(`TMR_A_CTLB, 8'h01);
      cpu.wr16(`TMR_A_CNTL, 16'h0010);
      cpu.rd(`TMR_A_CNTL, b);
      `CHK("write beats tick", 8'h11, b)
      cpu.wr(`TMR_A_CTLB, 8'h00);
      // Clock enable low: writes are not taken
      cpu.wr16(`TMR_A_CNTL, 16'h0500);
      ce <= 1'b0;
      cpu.wr16(`TMR_A_CNTL, 16'hbeef);
      ce <= 1'b1;
      cpu.rd16(`TMR_A_CNTL, w);
      `CHK("frozen write", 16'h0500, w)
      // Second reset in mid-run
      @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      `CHK("reset irq again", 1'b0, irq)
      `CHK("reset wave a", 1'b0, wave_a)
      `CHK("reset wave b", 1'b0, wave_b)
      cpu.rd(`TMR_A_CTLB, b);
      `CHK("reset control", 8'h00, b)
      cpu.rd16(`TMR_A_CNTL, w);
      `CHK("reset count", 16'h0000, w)
      tally_and_finish();
   end
endmodule : timer16_register_access_core_tb_top
